// *** core/core_regs_params.svh ***
// Offsets, field positions, reset values and timing constants for the core operational registers.
// Behaviour
// - The indirect port reads or writes the data location that the bank select register names.
// - The tick counter counts an external pin edge or the instruction clock.
// - Software writes and reads the tick counter freely; a write loads a new count.
// - Program counter and stack entries are 12 bits; pages are 1024 words.
// - Any reset clears the whole program counter to zero.
// - A jump loads its 10-bit target into the low program counter bits.
// - A call loads the low 10 bits and pushes the following address.
// - All return forms reload the counter from the stack top, pages untouched.
// - Adding the accumulator adds it to the count and clears bits 8 and 9.
// - Moving the accumulator loads the low 8 bits and clears bits 8 and 9.
// - A write to the program counter register clears counter bits 8 and 9; it is lost if an instruction is taken in the same cycle.
// - Jumps, calls and counter writes load the page pair into bits 11 and 10.
// - Instructions take one cycle of two clocks; jumps, calls, adds, moves and counter writes take one more, returns do not.
// - Page pair values 0 to 3 select the four 1024-word program ranges.
// - Status bit 7 shows the comparator; bits 6 and 5 hold the page pair.
// - The time-out bit is set at power-up, sleep and watchdog clear; cleared on expiry.
// - The power-down bit is set at power-on and watchdog clear; cleared by sleep.
// - Status bits 2, 1 and 0 hold zero, nibble carry and carry.
// - Bank select bits 5..0 give the address, bit 6 the bank, bit 7 is free.
// - The return stack holds eight levels.
// - Two port data registers; bit 0 of the first port is input only.
// - The counter enable pin high lets the tick counter advance, low stops it.
// - A low reset pin holds the device in reset; any change wakes it from sleep.
// - Source select 0 chooses the instruction clock, 1 the external pin.
// - Edge select 0 counts rising pin edges, 1 falling ones.
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH
`define OFS_INDIRECT 6'h00
`define OFS_TICK 6'h04
`define OFS_PC_LOW 6'h08
`define OFS_STATUS 6'h0c
`define OFS_BANK 6'h10
`define OFS_PORT_A 6'h14
`define OFS_PORT_B 6'h18
`define OFS_PRESCALE 6'h1c
`define OFS_PC_FULL 6'h20
`define OFS_STACK_PTR 6'h24
`define BIT_CMP 7
`define BIT_PS_HI 6
`define BIT_PS_LO 5
`define BIT_TIMEOUT 4
`define BIT_PWRDN 3
`define BIT_ZERO 2
`define BIT_AUX 1
`define BIT_CARRY 0
`define BIT_SRC_SEL 5
`define BIT_EDGE_SEL 4
`define STATUS_RESET 8'h18
`define PRESCALE_RESET 8'h00
`define BANK_RESET 8'h00
`define PORT_RESET 8'h00
`define PC_RESET 12'h000
`define PC_WIDTH 12
`define PAGE_BITS 10
`define STACK_DEPTH 8
`define CLKS_PER_INSTR 2
`endif

// *** core/core_regs_pkg.sv ***
// Types shared by the core operational registers and its execution partner.
package core_regs_pkg;
   typedef enum logic [3:0] {
      op_next,
      jump_op,
      call_op,
      return_op,
      return_literal_op,
      return_from_irq_op,
      add_pc_op,
      mov_pc_op,
      pc_write_op,
      sleep_op,
      watchdog_clear_op
   } exec_op_t;
   typedef struct packed {
      logic valid;
      exec_op_t op;
      logic [9:0] target;
      logic [7:0] acc;
   } exec_req_t;
   typedef struct packed {
      logic we;
      logic zero;
      logic nibble_overflow_bit;
      logic carry;
   } alu_flags_t;
endpackage : core_regs_pkg

// *** core/core_operational_registers.sv ***
// Core operational registers with program counter, return stack and Avalon-MM register access.
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_params.svh"
module core_operational_registers
   import core_regs_pkg::*;
#(
   parameter int STACK_LEVELS = `STACK_DEPTH,
   parameter int MEM_WORDS = 128
) (
   input wire logic sys_clk, // 100 MHz clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic [5:0] avs_address, // Byte address.
   input wire logic avs_read, // Read request.
   input wire logic avs_write, // Write request.
   input wire logic [31:0] avs_writedata, // Write data.
   input wire logic [3:0] avs_byteenable, // Byte lanes.
   output logic [31:0] avs_readdata, // Read data.
   output logic avs_waitrequest, // Wait request.
   input wire exec_req_t exec_req, // Instruction from the execution logic.
   input wire alu_flags_t alu_flags, // Result flags from the execution logic.
   input wire logic watchdog_expired, // One-cycle watchdog time-out pulse.
   input wire logic tick_counter, // External counter pin.
   input wire logic counter_enable_pin, // Counter enable pin.
   input wire logic reset_pin_n, // Reset pin, active low.
   input wire logic comparator_in, // Comparator result.
   input wire logic port_a_pin0, // Input-only pin of the first port.
   output logic [11:0] program_counter, // Current program address.
   output logic exec_busy, // Extra instruction cycle in progress.
   output logic instr_tick, // Instruction cycle enable.
   output logic sleeping, // Device asleep.
   output logic [7:0] port_a_out, // First port data.
   output logic [7:0] port_b_out // Second port data.
);
   localparam int SPW = $clog2(STACK_LEVELS);
   localparam int MAW = $clog2(MEM_WORDS);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic tcc_meta, tcc_sync, tcc_prev;
   logic en_meta, en_sync;
   logic rp_meta, rp_sync, rp_prev;
   logic cmp_meta, cmp_sync;
   logic pa0_meta, pa0_sync;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {tcc_meta, tcc_sync, tcc_prev} <= 3'h0;
         {en_meta, en_sync} <= 2'h0;
         {rp_meta, rp_sync, rp_prev} <= 3'h7;
         {cmp_meta, cmp_sync, pa0_meta, pa0_sync} <= 4'h0;
      end else begin
         {tcc_meta, tcc_sync, tcc_prev} <= {tick_counter, tcc_meta, tcc_sync};
         {en_meta, en_sync} <= {counter_enable_pin, en_meta};
         {rp_meta, rp_sync, rp_prev} <= {reset_pin_n, rp_meta, rp_sync};
         {cmp_meta, cmp_sync} <= {comparator_in, cmp_meta};
         {pa0_meta, pa0_sync} <= {port_a_pin0, pa0_meta};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction cycle divider and execution handshake.
   logic [7:0] status_flags, ram_bank_select, timer_count_value, prescale_control_reg;
   logic [7:0] port_a_data, port_b_data;
   logic [11:0] stack [STACK_LEVELS];
   logic [SPW-1:0] sp;
   logic [7:0] data_mem [MEM_WORDS];

   wire logic soft_rst = ~rp_sync;
   wire logic pin_changed = rp_sync ^ rp_prev;
   wire logic take = instr_tick & exec_req.valid & ~exec_busy & ~soft_rst;
   wire exec_op_t op = exec_req.op;
   wire logic is_return = (op == return_op) || (op == return_literal_op) || (op == return_from_irq_op);
   wire logic pc_modifier = take & (op inside {jump_op, call_op, add_pc_op, mov_pc_op, pc_write_op});
   wire logic [1:0] page_sel = status_flags[`BIT_PS_HI:`BIT_PS_LO];
   wire logic [SPW-1:0] sp_top = sp - SPW'(1);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         instr_tick <= 1'b0;
         exec_busy <= 1'b0;
      end else begin
         instr_tick <= ~instr_tick & ~soft_rst;
         if (soft_rst || (instr_tick && exec_busy)) begin
            exec_busy <= 1'b0;
         end else if (pc_modifier) begin
            exec_busy <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait state, registered read data.
   wire logic bus_req = avs_read | avs_write;
   wire logic bus_go = bus_req & ~avs_waitrequest;
   wire logic wr_lane = avs_write & bus_go & avs_byteenable[0];
   wire logic [7:0] wbyte = avs_writedata[7:0];
   wire logic wr_indirect = wr_lane && (avs_address == `OFS_INDIRECT);
   wire logic wr_tick = wr_lane && (avs_address == `OFS_TICK);
   wire logic wr_pc = wr_lane && (avs_address == `OFS_PC_LOW);
   wire logic wr_status = wr_lane && (avs_address == `OFS_STATUS);
   wire logic wr_bank = wr_lane && (avs_address == `OFS_BANK);
   wire logic wr_port_a = wr_lane && (avs_address == `OFS_PORT_A);
   wire logic wr_port_b = wr_lane && (avs_address == `OFS_PORT_B);
   wire logic wr_prescale = wr_lane && (avs_address == `OFS_PRESCALE);
   // Bank bit 6 with address bits 5..0.
   wire logic [MAW-1:0] ind_addr = MAW'(ram_bank_select[6:0]);
   // Comparator shows live in bit 7.
   wire logic [7:0] status_view = {cmp_sync, status_flags[6:0]};
   // Pin 0 of the first port reads the pin.
   wire logic [7:0] port_a_view = {port_a_data[7:1], pa0_sync};
   logic [7:0] rd_byte;
   always_comb begin
      case (avs_address)
         `OFS_INDIRECT: rd_byte = data_mem[ind_addr];
         `OFS_TICK: rd_byte = timer_count_value;
         `OFS_PC_LOW: rd_byte = program_counter[7:0];
         `OFS_STATUS: rd_byte = status_view;
         `OFS_BANK: rd_byte = ram_bank_select;
         `OFS_PORT_A: rd_byte = port_a_view;
         `OFS_PORT_B: rd_byte = port_b_data;
         `OFS_PRESCALE: rd_byte = prescale_control_reg;
         `OFS_PC_FULL: rd_byte = {4'h0, program_counter[11:8]};
         `OFS_STACK_PTR: rd_byte = 8'(sp);
         default: rd_byte = 8'h00;
      endcase
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Indirect data memory; the indirect port has no storage itself.
   always_ff @(posedge sys_clk) begin
      if (wr_indirect) begin
         data_mem[ind_addr] <= wbyte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tick counter.
   wire logic ext_rise = tcc_sync & ~tcc_prev;
   wire logic ext_fall = ~tcc_sync & tcc_prev;
   wire logic ext_edge = prescale_control_reg[`BIT_EDGE_SEL] ? ext_fall : ext_rise;
   wire logic count_src = prescale_control_reg[`BIT_SRC_SEL] ? ext_edge : instr_tick;
   wire logic count_inc = en_sync & count_src;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timer_count_value <= 8'h00;
         prescale_control_reg <= `PRESCALE_RESET;
      end else begin
         if (wr_tick) begin
            timer_count_value <= wbyte;
         end else if (count_inc) begin
            timer_count_value <= timer_count_value + 8'h01;
         end
         if (wr_prescale) begin
            prescale_control_reg <= wbyte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter and return stack.
   // Page pair into the top bits.
   // Page pair picks the 1024-word range.
   wire logic [11:0] pc_jump = {page_sel, exec_req.target};
   wire logic [11:0] pc_plus1 = program_counter + 12'h001;
   // Relative add with bits 8 and 9 cleared.
   wire logic [11:0] pc_add = {page_sel, 2'b00, program_counter[7:0] + exec_req.acc};
   wire logic [11:0] pc_mov = {page_sel, 2'b00, exec_req.acc};
   // Software write clears bits 8 and 9.
   wire logic [11:0] pc_bus = {page_sel, 2'b00, wbyte};
   logic [11:0] next_pc;
   always_comb begin
      next_pc = program_counter;
      if (take) begin
         case (op)
            op_next: next_pc = pc_plus1;
            jump_op: next_pc = pc_jump;
            call_op: next_pc = pc_jump;
            return_op, return_literal_op, return_from_irq_op: next_pc = stack[sp_top];
            add_pc_op: next_pc = pc_add;
            mov_pc_op, pc_write_op: next_pc = pc_mov;
            default: next_pc = pc_plus1;
         endcase
      end else if (wr_pc) begin
         next_pc = pc_bus;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         program_counter <= `PC_RESET;
         sp <= '0;
      end else if (soft_rst) begin
         program_counter <= `PC_RESET;
         sp <= '0;
      end else begin
         program_counter <= next_pc;
         if (take && op == call_op) begin
            sp <= sp + SPW'(1);
         end else if (take && is_return) begin
            sp <= sp_top;
         end
      end
   end

   for (genvar i = 0; i < STACK_LEVELS; i++) begin : g_stack
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            stack[i] <= `PC_RESET;
         end else if (take && op == call_op && sp == SPW'(i)) begin
            stack[i] <= pc_plus1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status, bank select, ports and sleep.
   wire logic do_sleep = take & (op == sleep_op);
   wire logic do_watchdog_clear_op = take & (op == watchdog_clear_op);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_flags <= `STATUS_RESET;
         ram_bank_select <= `BANK_RESET;
         port_a_data <= `PORT_RESET;
         port_b_data <= `PORT_RESET;
         sleeping <= 1'b0;
      end else begin
         if (wr_status) begin
            status_flags[6:5] <= wbyte[6:5];
            status_flags[2:0] <= wbyte[2:0];
         end
         if (alu_flags.we) begin
            status_flags[2:0] <= {alu_flags.zero, alu_flags.nibble_overflow_bit, alu_flags.carry};
         end
         if (do_sleep || do_watchdog_clear_op) begin
            status_flags[`BIT_TIMEOUT] <= 1'b1;
         end else if (watchdog_expired) begin
            status_flags[`BIT_TIMEOUT] <= 1'b0;
         end
         if (do_watchdog_clear_op) begin
            status_flags[`BIT_PWRDN] <= 1'b1;
         end else if (do_sleep) begin
            status_flags[`BIT_PWRDN] <= 1'b0;
         end
         status_flags[`BIT_CMP] <= cmp_sync;
         if (wr_bank) begin
            ram_bank_select <= wbyte;
         end
         if (wr_port_a) begin
            port_a_data <= {wbyte[7:1], 1'b0};
         end
         if (wr_port_b) begin
            port_b_data <= wbyte;
         end
         if (pin_changed) begin
            sleeping <= 1'b0;
         end else if (do_sleep) begin
            sleeping <= 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         port_a_out <= `PORT_RESET;
         port_b_out <= `PORT_RESET;
      end else begin
         port_a_out <= port_a_data;
         port_b_out <= port_b_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_pc_pin_reset: assert property (soft_rst |=> program_counter == 12'h000)
      else $error("program counter not cleared by reset pin");
   a_jump_target: assert property (take && op == jump_op |=> program_counter == {$past(page_sel), $past(exec_req.target)})
      else $error("jump target not loaded");
   a_call_push: assert property (take && op == call_op |=> stack[$past(sp)] == $past(program_counter) + 12'h001 && sp == $past(sp) + SPW'(1))
      else $error("call did not push return address");
   a_return_pop: assert property (take && is_return && !wr_status |=> program_counter == $past(stack[sp_top]) && $stable(status_flags[6:5]))
      else $error("return did not restore counter");
   a_add_clear: assert property (take && op == add_pc_op |=> program_counter[9:8] == 2'b00 && program_counter[7:0] == 8'($past(program_counter[7:0]) + $past(exec_req.acc)))
      else $error("relative add wrong");
   a_mov_low: assert property (take && op == mov_pc_op |=> program_counter == {$past(page_sel), 2'b00, $past(exec_req.acc)})
      else $error("accumulator move wrong");
   a_extra_cycle: assert property (pc_modifier |=> exec_busy [*2] ##1 !exec_busy)
      else $error("extra instruction cycle wrong");
   a_timer_hold: assert property (!en_sync && !wr_tick |=> $stable(timer_count_value))
      else $error("tick counter moved while disabled");
   a_sleep_bits: assert property (do_sleep && !pin_changed |=> status_flags[4:3] == 2'b10 && sleeping)
      else $error("sleep status bits wrong");
   a_port_a_input: assert property (avs_read && avs_waitrequest && avs_address == `OFS_PORT_A |=> avs_readdata[0] == $past(pa0_sync))
      else $error("first port bit 0 not read from pin");

   // Counter, status, wake and stack checks.
   // Instruction clock source.
   a_tick_source: assert property (en_sync && !prescale_control_reg[`BIT_SRC_SEL] && !wr_tick |=>
      timer_count_value == $past(timer_count_value) + 8'($past(instr_tick)))
      else $error("tick counter missed an instruction tick");

   a_tick_load: assert property (wr_tick |=>
      timer_count_value == $past(wbyte))
      else $error("tick counter write not loaded");

   a_pc_bus_write: assert property (wr_pc && !take && !soft_rst |=>
      program_counter == {$past(page_sel), 2'b00, $past(wbyte)})
      else $error("counter write did not clear bits 8 and 9");

   a_watchdog_clear_op_bits: assert property (do_watchdog_clear_op |=>
      status_flags[`BIT_TIMEOUT] && status_flags[`BIT_PWRDN])
      else $error("watchdog clear status bits wrong");

   a_timeout_clear: assert property (watchdog_expired && !do_sleep && !do_watchdog_clear_op |=>
      !status_flags[`BIT_TIMEOUT])
      else $error("time-out bit not cleared on expiry");

   a_wake_pin: assert property (pin_changed |=>
      !sleeping)
      else $error("pin change did not wake the device");

   a_stack_wrap: assert property (take && op == call_op && sp == SPW'(STACK_LEVELS - 1) |=>
      sp == '0)
      else $error("stack pointer did not wrap");

   c_call_return: cover property (take && op == call_op ##[1:20] take && is_return);
   c_ext_count: cover property (prescale_control_reg[`BIT_SRC_SEL] && count_inc);
   c_bus_write: cover property (wr_indirect);
   c_wake: cover property (sleeping ##1 pin_changed);
   c_stack_wrap: cover property (take && op == call_op && sp == SPW'(STACK_LEVELS - 1));
endmodule : core_operational_registers
`default_nettype wire

// *** dv/exec_partner.sv ***
// Execution-side model that issues instructions and result flags to the register block.
`timescale 1ns/1ps
`default_nettype none
module exec_partner
   import core_regs_pkg::*;
(
   input wire logic sys_clk, // Clock.
   input wire logic instr_tick, // Instruction slot enable.
   input wire logic exec_busy, // Extra instruction cycle.
   output var exec_req_t exec_req, // Instruction request.
   output var alu_flags_t alu_flags // Result flags.
);
   initial begin
      exec_req = '0;
      alu_flags = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // A stall makes the partner slow; the request is held until a free slot takes it.
   task automatic issue(input exec_op_t op, input logic [9:0] t, input logic [7:0] a, input int stall);
      repeat (stall + 1) @(posedge sys_clk);
      exec_req <= '{1'b1, op, t, a};
      do @(posedge sys_clk); while (!(instr_tick === 1'b1 && exec_busy === 1'b0));
      // Released fields are scrambled so that no stale value can pass for a live one.
      exec_req <= '{1'b0, op, ~t, ~a};
   endtask : issue
   ////////////////////////////////////////////////////////////////////////////////
   task automatic flags(input logic [2:0] f);
      @(posedge sys_clk);
      alu_flags <= {1'b1, f};
      @(posedge sys_clk);
      alu_flags.we <= 1'b0;
   endtask : flags
endmodule : exec_partner
`default_nettype wire

// *** dv/core_operational_registers_test.sv ***
// Self-checking testbench for the core operational registers.
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_params.svh"
module core_operational_registers_test
   import core_regs_pkg::*;
;
   logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, watchdog_expired, tick_counter;
   logic counter_enable_pin, reset_pin_n, comparator_in, port_a_pin0, exec_busy, instr_tick, sleeping;
   logic [5:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd, seed, d;
   logic [11:0] program_counter;
   logic [7:0] port_a_out, port_b_out;
   logic [11:0] stk [8];
   logic [7:0] mem [128];
   logic [7:0] bq [$];
   exec_req_t exec_req;
   alu_flags_t alu_flags;
   int n_fail, cmp_count, pc_m, sp, ps, i, j;
   exec_op_t seq [6] = '{jump_op, call_op, add_pc_op, mov_pc_op, pc_write_op, op_next};
   exec_op_t rets [3] = '{return_op, return_literal_op, return_from_irq_op};
   logic [5:0] ofs [3] = '{`OFS_TICK, `OFS_BANK, `OFS_PORT_B};

   core_operational_registers u_core_operational_registers (.sys_clk(sys_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .exec_req(exec_req), .alu_flags(alu_flags), .watchdog_expired(watchdog_expired),
      .tick_counter(tick_counter), .counter_enable_pin(counter_enable_pin), .reset_pin_n(reset_pin_n),
      .comparator_in(comparator_in), .port_a_pin0(port_a_pin0), .program_counter(program_counter),
      .exec_busy(exec_busy), .instr_tick(instr_tick), .sleeping(sleeping), .port_a_out(port_a_out),
      .port_b_out(port_b_out));
   exec_partner u_exec_partner (.sys_clk(sys_clk), .instr_tick(instr_tick), .exec_busy(exec_busy),
      .exec_req(exec_req), .alu_flags(alu_flags));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nx();
      seed = {seed[30:0], ^(seed & 32'h80200003)};
      return seed;
   endfunction : nx
   task automatic report(input string w, input logic [31:0] g, input logic [31:0] e);
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, g, e);
   endtask : report
   task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) report("bus", g, e);
   endtask : chk_bus
   task automatic chk_pc(input logic [11:0] g, input int e);
      cmp_count++;
      if (g !== e[11:0]) report("pc", {20'h0, g}, e);
   endtask : chk_pc
   task automatic chk_bit(input logic g, input logic e);
      cmp_count++;
      if (g !== e) report("bit", {31'h0, g}, {31'h0, e});
   endtask : chk_bit
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   // One Avalon transfer; the request stands until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {seed[31:8], v};
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [5:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk_bus(rd, {24'h0, e});
   endtask : rchk
   // Model of the counter and return stack, then one instruction through the partner.
   task automatic run(input exec_op_t op);
      logic [31:0] r;
      r = nx();
      case (op)
         op_next: pc_m = (pc_m + 1) % 4096;
         jump_op: pc_m = ps * 1024 + r[9:0];
         call_op: begin
            stk[sp] = pc_m + 1;
            sp = (sp + 1) % 8;
            pc_m = ps * 1024 + r[9:0];
         end
         add_pc_op: pc_m = ps * 1024 + (pc_m + r[17:10]) % 256;
         mov_pc_op, pc_write_op: pc_m = ps * 1024 + r[17:10];
         default: begin
            sp = (sp + 7) % 8;
            pc_m = stk[sp];
         end
      endcase
      u_exec_partner.issue(op, r[9:0], r[17:10], int'(r[19:18]));
      @(posedge sys_clk);
      chk_pc(program_counter, pc_m);
      chk_bit(exec_busy, op inside {jump_op, call_op, add_pc_op, mov_pc_op, pc_write_op});
      chk_bit(instr_tick, 1'b0);
   endtask : run
   task automatic pin_reset();
      @(posedge sys_clk);
      reset_pin_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      reset_pin_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      pc_m = 0;
      sp = 0;
      chk_pc(program_counter, 0);
      chk_bit(sleeping, 1'b0);
   endtask : pin_reset
   task automatic pulses(input logic idle);
      repeat (5) begin
         repeat (4) @(posedge sys_clk);
         tick_counter <= ~idle;
         repeat (4) @(posedge sys_clk);
         tick_counter <= idle;
      end
      repeat (6) @(posedge sys_clk);
   endtask : pulses
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #300000;
      n_fail++;
      end_sim();
   end
   initial begin
      {avs_read, avs_write, watchdog_expired, tick_counter, counter_enable_pin, comparator_in} = '0;
      {avs_address, avs_writedata, port_a_pin0, pc_m, sp, ps, n_fail, cmp_count} = '0;
      {rst, reset_pin_n, avs_byteenable, seed} = {1'b1, 1'b1, 4'hf, 32'he59ce82d};
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      chk_pc(program_counter, 0);
      rchk(`OFS_STATUS, `STATUS_RESET);
      rchk(`OFS_PRESCALE, `PRESCALE_RESET);
      for (i = 0; i < 3; i++) begin
         d = nx();
         bus(1'b1, ofs[i], d[7:0]);
         rchk(ofs[i], d[7:0]);
      end
      chk_bus({24'h0, port_b_out}, {24'h0, d[7:0]});
      avs_byteenable <= 4'he;
      bus(1'b1, `OFS_PORT_B, ~d[7:0]);
      avs_byteenable <= 4'hf;
      rchk(`OFS_PORT_B, d[7:0]);
      bus(1'b1, 6'h28, d[7:0]);
      rchk(6'h28, 8'h00);
      port_a_pin0 <= d[9];
      bus(1'b1, `OFS_PORT_A, d[7:0]);
      rchk(`OFS_PORT_A, {d[7:1], d[9]});
      chk_bus({24'h0, port_a_out}, {24'h0, d[7:1], 1'b0});
      for (i = 0; i < 4; i++) begin
         d = nx();
         bq.push_back(d[7:0]);
         mem[d[6:0]] = d[15:8];
         bus(1'b1, `OFS_BANK, d[7:0]);
         bus(1'b1, `OFS_INDIRECT, d[15:8]);
      end
      foreach (bq[k]) begin
         bus(1'b1, `OFS_BANK, bq[k]);
         rchk(`OFS_INDIRECT, mem[bq[k][6:0]]);
      end
      comparator_in <= 1'b1;
      bus(1'b1, `OFS_STATUS, 8'h00);
      rchk(`OFS_STATUS, 8'h98);
      u_exec_partner.flags(3'b101);
      rchk(`OFS_STATUS, 8'h9d);
      for (i = 0; i < 4; i++) begin
         bus(1'b1, `OFS_STATUS, {1'b0, 2'(i), 5'h00});
         ps = i;
         for (j = 0; j < 6; j++) run(seq[j]);
         bus(1'b1, `OFS_STATUS, {1'b0, 2'(i + 1), 5'h00});
         ps = (i + 1) % 4;
         run(rets[i % 3]);
         bus(1'b1, `OFS_PC_LOW, d[7:0]);
         pc_m = ps * 1024 + d[7:0];
         @(posedge sys_clk);
         chk_pc(program_counter, pc_m);
         rchk(`OFS_PC_FULL, 8'(pc_m >> 8));
      end
      for (i = 0; i < 9; i++) run(call_op);
      rchk(`OFS_STACK_PTR, 8'(sp));
      for (i = 0; i < 10; i++) run(rets[i % 3]);
      counter_enable_pin <= 1'b1;
      for (i = 0; i < 2; i++) begin
         tick_counter <= i[0];
         repeat (6) @(posedge sys_clk);
         bus(1'b1, `OFS_PRESCALE, {2'b00, 1'b1, i[0], 4'h0});
         d = nx();
         bus(1'b1, `OFS_TICK, d[7:0]);
         pulses(i[0]);
         rchk(`OFS_TICK, d[7:0] + 8'h05);
      end
      counter_enable_pin <= 1'b0;
      pulses(1'b1);
      rchk(`OFS_TICK, d[7:0] + 8'h05);
      @(posedge sys_clk);
      watchdog_expired <= 1'b1;
      @(posedge sys_clk);
      watchdog_expired <= 1'b0;
      bus(1'b0, `OFS_STATUS, 8'h00);
      chk_bit(rd[`BIT_TIMEOUT], 1'b0);
      u_exec_partner.issue(sleep_op, 10'h000, 8'h00, 0);
      repeat (2) @(posedge sys_clk);
      chk_bit(sleeping, 1'b1);
      bus(1'b0, `OFS_STATUS, 8'h00);
      chk_bit(rd[`BIT_TIMEOUT], 1'b1);
      chk_bit(rd[`BIT_PWRDN], 1'b0);
      pin_reset();
      u_exec_partner.issue(watchdog_clear_op, 10'h000, 8'h00, 1);
      bus(1'b0, `OFS_STATUS, 8'h00);
      chk_bit(rd[`BIT_PWRDN], 1'b1);
      pin_reset();
      end_sim();
   end
endmodule : core_operational_registers_test
`default_nettype wire
